// [rtl/itb_pkg.sv]
// Package: constants and types for the IEC timer bank
package itb_pkg;

  // ---------------------------------------------------------------
  // Timer modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ITB_MODE_ON_DELAY  = 2'b00,
    ITB_MODE_OFF_DELAY = 2'b01,
    ITB_MODE_PULSE     = 2'b10,
    ITB_MODE_NONE      = 2'b11
  } itb_mode_t;

  // ---------------------------------------------------------------
  // Timer state machine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ITB_ST_IDLE = 2'b00,
    ITB_ST_RUN  = 2'b01,
    ITB_ST_DONE = 2'b10
  } itb_state_t;

  // ---------------------------------------------------------------
  // Time base selection
  // ---------------------------------------------------------------
  localparam logic [1:0] ITB_BASE_1MS = 2'h0;
  localparam logic [1:0] ITB_BASE_10MS = 2'h1;
  localparam logic [1:0] ITB_BASE_100MS = 2'h2;

  // ---------------------------------------------------------------
  // Index ranges
  // ---------------------------------------------------------------
  localparam logic [7:0] ITB_IDX_LO_FIRST = 8'h20;
  localparam logic [7:0] ITB_IDX_LO_LAST = 8'h3f;
  localparam logic [7:0] ITB_IDX_HI_FIRST = 8'h60;
  localparam logic [7:0] ITB_IDX_HI_LAST = 8'hff;
  localparam logic [7:0] ITB_IDX_1MS_A = 8'h20;
  localparam logic [7:0] ITB_IDX_1MS_B = 8'h60;
  localparam logic [7:0] ITB_IDX_10MS_A_LAST = 8'h24;
  localparam logic [7:0] ITB_IDX_10MS_B_LAST = 8'h64;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int ITB_CLK_HZ = 25000000;
  localparam int ITB_TICK_1MS_US = 1000;
  localparam int ITB_TICK_1MS_CYC = ITB_CLK_HZ / 1000000 * ITB_TICK_1MS_US;
  localparam int ITB_TICK_DECADE = 10;

  // ---------------------------------------------------------------
  // Reset value and saturation limit of elapsed time
  // ---------------------------------------------------------------
  localparam logic [15:0] ITB_ET_RESET = 16'h0000;
  localparam logic [15:0] ITB_ET_MAX = 16'h7fff;

endpackage

// [rtl/itb_timer_bank.sv]
// Module: bank of on-delay, off-delay and pulse timers
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RULE1: Each timer index serves only one mode; the bank runs whatever mode TMR_MODE gives each cycle.
// RULE2: On-delay counts per tick while enabled.
// RULE3: On-delay output sets when elapsed equals preset.
// RULE4: On-delay output clears when enable drops.
// RULE5: On-delay stops counting at preset.
// RULE6: Off-delay counts only after enable falls.
// RULE7: Off-delay clears output at preset, holds elapsed.
// RULE8: Off-delay re-enable before preset keeps output.
// RULE9: Pulse sets output on enable rise, counts.
// RULE10: Pulse clears output when elapsed reaches preset.
// RULE11: Pulse holds elapsed until enable drops.
// RULE12: Pulse output ignores enable during pulse.
// RULE13: Elapsed count unit equals one time base.
// RULE14: Indices 32, 96 use 1 ms base.
// RULE15: Indices 33-36, 97-100 use 10 ms base.
// RULE16: Indices 37-63, 101-255 use 100 ms base.
// RULE17: Only valid indices; preset, elapsed signed 16-bit.
// RULE18: Ticks derived from clock, per-resolution advance.
// RULE19: Reset clears all; off-delay awaits falling enable.
module itb_timer_bank
  import itb_pkg::*;
#(
  parameter int TICK_1MS_CYC = ITB_TICK_1MS_CYC
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // Per-timer control, indexed by timer number
  input wire logic [255:0] TMR_ENABLE,
  input wire logic [1:0] TMR_MODE [256],
  input wire logic signed [15:0] TMR_PRESET_TIME [256],
  // Per-timer results
  output logic [255:0] TMR_OUT,
  output logic signed [15:0] TMR_ELAPSED_TIME [256]
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic idx_valid(input logic [7:0] idx);
    idx_valid = (idx >= ITB_IDX_LO_FIRST && idx <= ITB_IDX_LO_LAST) ||
                (idx >= ITB_IDX_HI_FIRST && idx <= ITB_IDX_HI_LAST); // RULE17
  endfunction

  function automatic logic [1:0] idx_base(input logic [7:0] idx);
    if (idx == ITB_IDX_1MS_A || idx == ITB_IDX_1MS_B)
    begin
      idx_base = ITB_BASE_1MS; // RULE14
    end
    else if ((idx > ITB_IDX_1MS_A && idx <= ITB_IDX_10MS_A_LAST) ||
             (idx > ITB_IDX_1MS_B && idx <= ITB_IDX_10MS_B_LAST))
    begin
      idx_base = ITB_BASE_10MS; // RULE15
    end
    else
    begin
      idx_base = ITB_BASE_100MS; // RULE16
    end
  endfunction

  // ---------------------------------------------------------------
  // Elapsed time arithmetic
  // ---------------------------------------------------------------
  // Advances elapsed time by one unit, held at the signed maximum
  function automatic logic signed [15:0] et_step(input logic signed [15:0] et);
    if (et >= $signed(ITB_ET_MAX))
    begin
      et_step = et; // RULE17
    end
    else
    begin
      et_step = et + 16'sd1; // RULE13
    end
  endfunction

  // ---------------------------------------------------------------
  // Tick generator
  // ---------------------------------------------------------------
  logic [15:0] pre_q;
  logic [3:0] dec10_q;
  logic [3:0] dec100_q;
  logic tick1_q;
  logic tick10_q;
  logic tick100_q;

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pre_q <= 16'h0000;
      dec10_q <= 4'h0;
      dec100_q <= 4'h0;
      tick1_q <= 1'b0;
      tick10_q <= 1'b0;
      tick100_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      tick1_q <= 1'b0;
      tick10_q <= 1'b0;
      tick100_q <= 1'b0;
      if (pre_q == 16'(TICK_1MS_CYC - 1))
      begin
        pre_q <= 16'h0000; // RULE18
        tick1_q <= 1'b1;
        if (dec10_q == 4'(ITB_TICK_DECADE - 1))
        begin
          dec10_q <= 4'h0;
          tick10_q <= 1'b1;
          if (dec100_q == 4'(ITB_TICK_DECADE - 1))
          begin
            dec100_q <= 4'h0;
            tick100_q <= 1'b1;
          end
          else
          begin
            dec100_q <= dec100_q + 4'h1;
          end
        end
        else
        begin
          dec10_q <= dec10_q + 4'h1;
        end
      end
      else
      begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 256; g++)
  begin : g_tmr
    localparam logic [7:0] IDX = 8'(g);
    logic tick;
    logic en;
    logic rise;
    logic fall;
    logic at_preset;
    logic en_prev_q;
    logic out_q;
    logic signed [15:0] et_q;
    itb_state_t st_q;
    itb_mode_t mode;

    // -------------------------------------------------------------
    // Time base and enable edges
    // -------------------------------------------------------------
    always_comb
    begin
      case (idx_base(IDX))
        ITB_BASE_1MS: tick = tick1_q;
        ITB_BASE_10MS: tick = tick10_q;
        default: tick = tick100_q;
      endcase
    end

    assign en = TMR_ENABLE[g];
    assign rise = en && !en_prev_q;
    assign fall = !en && en_prev_q;
    assign mode = itb_mode_t'(TMR_MODE[g]); // RULE1
    assign at_preset = (et_q >= TMR_PRESET_TIME[g]);

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
      if (!RST_B)
      begin
        en_prev_q <= 1'b0; // RULE19
      end
      else if (CLK_EN && idx_valid(IDX))
      begin
        en_prev_q <= en;
      end
    end

    // -------------------------------------------------------------
    // Results
    // -------------------------------------------------------------
    assign TMR_OUT[g] = out_q;
    assign TMR_ELAPSED_TIME[g] = et_q;

    // -------------------------------------------------------------
    // Mode sequencing
    // -------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
      if (!RST_B)
      begin
        st_q <= ITB_ST_IDLE; // RULE19
        out_q <= 1'b0;
        et_q <= ITB_ET_RESET;
      end
      else if (CLK_EN && idx_valid(IDX))
      begin
        case (mode)
          ITB_MODE_ON_DELAY:
          begin
            if (!en)
            begin
              out_q <= 1'b0; // RULE4
              et_q <= ITB_ET_RESET;
              st_q <= ITB_ST_IDLE;
            end
            else if (at_preset)
            begin
              out_q <= 1'b1; // RULE3 RULE5
              st_q <= ITB_ST_DONE;
            end
            else if (tick)
            begin
              et_q <= et_step(et_q); // RULE2 RULE13
              st_q <= ITB_ST_RUN;
            end
          end
          ITB_MODE_OFF_DELAY:
          begin
            if (en)
            begin
              out_q <= 1'b1; // RULE8
              et_q <= ITB_ET_RESET;
              st_q <= ITB_ST_IDLE;
            end
            else if (fall)
            begin
              st_q <= ITB_ST_RUN; // RULE6 RULE19
            end
            else if (st_q == ITB_ST_RUN)
            begin
              if (at_preset)
              begin
                out_q <= 1'b0; // RULE7
                st_q <= ITB_ST_DONE;
              end
              else if (tick)
              begin
                et_q <= et_step(et_q); // RULE6 RULE13
              end
            end
          end
          ITB_MODE_PULSE:
          begin
            case (st_q)
              ITB_ST_IDLE:
              begin
                if (rise)
                begin
                  out_q <= 1'b1; // RULE9
                  et_q <= ITB_ET_RESET;
                  st_q <= ITB_ST_RUN;
                end
              end
              ITB_ST_RUN:
              begin
                if (at_preset)
                begin
                  out_q <= 1'b0; // RULE10
                  st_q <= ITB_ST_DONE;
                end
                else if (tick)
                begin
                  et_q <= et_step(et_q); // RULE12 RULE13
                end
              end
              ITB_ST_DONE:
              begin
                if (!en)
                begin
                  et_q <= ITB_ET_RESET; // RULE11
                  st_q <= ITB_ST_IDLE;
                end
              end
              default:
              begin
                st_q <= ITB_ST_IDLE;
              end
            endcase
          end
          default:
          begin
            out_q <= 1'b0;
            et_q <= ITB_ET_RESET;
            st_q <= ITB_ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // itb_timer_bank

`default_nettype wire

// [test/itb_ctrl_model.sv]
// Partner model: controller logic driving timer enables, modes and presets
`timescale 1ns/1ns
`default_nettype none
module itb_ctrl_model
  import itb_pkg::*;
(
  // Clock
  input wire logic clk,
  // Timer controls
  output logic [255:0] en,
  output logic [1:0] md [256],
  output logic signed [15:0] pt [256]
);
  logic [1:0] owner [256];
  initial
  begin
    en = 256'h0;
    md = '{default: 2'h3};
    pt = '{default: 16'h0};
    owner = '{default: 2'h3};
  end
  // Applies one command at the falling edge
  task automatic drive(input int i, input logic [1:0] m, input logic [15:0] p, input logic e);
    @(negedge clk);
    if (owner[i] == 2'h3)
      owner[i] = m;
    if (m == 2'h3 || m == owner[i])
    begin
      md[i] = m;
      pt[i] = p;
      en[i] = e;
    end
  endtask
endmodule // itb_ctrl_model
`default_nettype wire

// [test/itb_timer_bank_assertions.sv]
// Checker: timing relations of timers 32, 96 and 33
`timescale 1ns/1ns
`default_nettype none
module itb_timer_bank_chk
  import itb_pkg::*;
#(
  parameter int TICK_1MS_CYC = ITB_TICK_1MS_CYC
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // Timer controls
  input wire logic [255:0] TMR_ENABLE,
  input wire logic [1:0] TMR_MODE [256],
  input wire logic signed [15:0] TMR_PRESET_TIME [256],
  // Timer results
  input wire logic [255:0] TMR_OUT,
  input wire logic signed [15:0] TMR_ELAPSED_TIME [256]
);
  wire om = TMR_MODE[32] == ITB_MODE_ON_DELAY;
  wire oe = TMR_ENABLE[32];
  wire oq = TMR_OUT[32];
  wire signed [15:0] oet = TMR_ELAPSED_TIME[32];
  wire signed [15:0] opt = TMR_PRESET_TIME[32];
  wire fm = TMR_MODE[96] == ITB_MODE_OFF_DELAY;
  wire fe = TMR_ENABLE[96];
  wire fq = TMR_OUT[96];
  wire signed [15:0] fet = TMR_ELAPSED_TIME[96];
  wire pm = TMR_MODE[33] == ITB_MODE_PULSE;
  wire pq = TMR_OUT[33];
  wire pe = TMR_ENABLE[33];
  wire signed [15:0] pet = TMR_ELAPSED_TIME[33];
  wire signed [15:0] ppt = TMR_PRESET_TIME[33];
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B || !CLK_EN);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_on_clr; om && !oe |=> !oq && oet == 16'sh0; endproperty
  a_on_clr: assert property (p_on_clr) else $error("on clear");
  property p_on_set; om && oe && oet == opt ##1 oe ##1 oe |-> oq; endproperty
  a_on_set: assert property (p_on_set) else $error("on set");
  property p_on_hold; om && oe && oq |=> $stable(oet); endproperty
  a_on_hold: assert property (p_on_hold) else $error("on hold");
  property p_on_step; om && $past(oe) && $changed(oet) |-> oet == $past(oet) + 16'sh1; endproperty
  a_on_step: assert property (p_on_step) else $error("on step");
  property p_off_on; fm && fe |=> fq && fet == 16'sh0; endproperty
  a_off_on: assert property (p_off_on) else $error("off on");
  property p_off_hold; fm && !fe && !fq |=> $stable(fet); endproperty
  a_off_hold: assert property (p_off_hold) else $error("off hold");
  property p_pls_keep; pm && pq && pet < ppt |=> pq; endproperty
  a_pls_keep: assert property (p_pls_keep) else $error("pulse keep");
  property p_pls_end; pm && pq && pet == ppt |-> ##[1:2] !pq; endproperty
  a_pls_end: assert property (p_pls_end) else $error("pulse end");
  property p_pls_start; pm && $rose(pe) && $past(CLK_EN) |=> pq; endproperty
  a_pls_start: assert property (p_pls_start) else $error("pulse start");
  c_on: cover property (om && oq);
  c_off: cover property (fm && $fell(fq));
  c_pls: cover property (pm && $fell(pq));
endmodule // itb_timer_bank_chk
bind itb_timer_bank itb_timer_bank_chk #(.TICK_1MS_CYC(TICK_1MS_CYC)) u_itb_timer_bank_chk (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN), .TMR_ENABLE(TMR_ENABLE),
  .TMR_MODE(TMR_MODE), .TMR_PRESET_TIME(TMR_PRESET_TIME), .TMR_OUT(TMR_OUT),
  .TMR_ELAPSED_TIME(TMR_ELAPSED_TIME));
`default_nettype wire

// [test/test_itb_timer_bank.sv]
// Testbench: timer bank driven by the controller model
`timescale 1ns/1ns
`default_nettype none
module test_itb_timer_bank
  import itb_pkg::*;
();
  localparam int T1 = 10;
  typedef struct {int i; logic [1:0] m; logic [15:0] p; int tk; logic q_mid; logic q_end;} itb_row_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  wire logic [255:0] en;
  wire logic [1:0] md [256];
  wire logic signed [15:0] pt [256];
  wire logic [255:0] q;
  wire logic signed [15:0] et [256];
  int miscompares = 0;
  int comparisons = 0;
  itb_row_t w;
  itb_row_t rows [7] = '{'{32, 0, 3, T1, 0, 1}, '{96, 1, 3, T1, 1, 0}, '{33, 2, 3, 10 * T1, 1, 0},
    '{100, 0, 2, 10 * T1, 0, 1}, '{37, 1, 2, 100 * T1, 1, 0}, '{255, 2, 2, 100 * T1, 1, 0},
    '{63, 0, 2, 100 * T1, 0, 1}};
  itb_timer_bank #(.TICK_1MS_CYC(T1)) u_itb_timer_bank (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .CLK_EN(clk_en), .TMR_ENABLE(en), .TMR_MODE(md), .TMR_PRESET_TIME(pt), .TMR_OUT(q),
    .TMR_ELAPSED_TIME(et));
  itb_ctrl_model u_itb_ctrl_model (.clk(sys_clk), .en(en), .md(md), .pt(pt));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // Reset, table rows, then the awkward cases
  // ---------------------------------------------------------------
  initial
  begin
    cyc(12);
    chk(q[47:32], 16'h0);
    chk(et[32], 16'h0);
    rst_b = 1'b1;
    u_itb_ctrl_model.drive(96, 2'h1, 16'h2, 1'b0);
    cyc(5 * T1);
    chk(q[96], 1'b0);
    chk(et[96], 16'h0);
    $display("Test reset done");
    foreach (rows[r])
    begin
      w = rows[r];
      u_itb_ctrl_model.drive(w.i, w.m, w.p, 1'b1);
      if (w.m == 2'h1)
      begin
        cyc(3);
        chk(q[w.i], 1'b1);
        u_itb_ctrl_model.drive(w.i, w.m, w.p, 1'b0);
      end
      cyc((w.p - 1) * w.tk);
      chk(q[w.i], w.q_mid);
      cyc(2 * w.tk + 4);
      chk(q[w.i], w.q_end);
      chk(et[w.i], w.p);
      u_itb_ctrl_model.drive(w.i, w.m, w.p, w.m == 2'h1);
      cyc(3);
      chk(q[w.i], w.m == 2'h1);
      chk(et[w.i], 16'h0);
      u_itb_ctrl_model.drive(w.i, 2'h3, 16'h0, 1'b0);
      $display("Test row %0d done", r);
    end
    clk_en = 1'b0;
    u_itb_ctrl_model.drive(32, 2'h0, 16'h3, 1'b1);
    cyc(5 * T1);
    chk(et[32], 16'h0);
    chk(q[32], 1'b0);
    clk_en = 1'b1;
    cyc(5 * T1);
    chk(q[32], 1'b1);
    chk(et[32], 16'h3);
    u_itb_ctrl_model.drive(32, 2'h0, 16'h3, 1'b0);
    $display("Test freeze done");
    u_itb_ctrl_model.drive(96, 2'h1, 16'h5, 1'b1);
    u_itb_ctrl_model.drive(96, 2'h1, 16'h5, 1'b0);
    cyc(2 * T1);
    chk(q[96], 1'b1);
    u_itb_ctrl_model.drive(96, 2'h1, 16'h5, 1'b1);
    cyc(3);
    chk(q[96], 1'b1);
    chk(et[96], 16'h0);
    u_itb_ctrl_model.drive(96, 2'h3, 16'h0, 1'b0);
    $display("Test off re-enable done");
    u_itb_ctrl_model.drive(33, 2'h2, 16'h3, 1'b1);
    u_itb_ctrl_model.drive(33, 2'h2, 16'h3, 1'b0);
    cyc(10 * T1);
    chk(q[33], 1'b1);
    cyc(30 * T1);
    chk(q[33], 1'b0);
    u_itb_ctrl_model.drive(33, 2'h2, 16'h3, 1'b1);
    cyc(3);
    chk(q[33], 1'b1);
    $display("Test pulse done");
    u_itb_ctrl_model.drive(96, 2'h1, 16'h2, 1'b1);
    cyc(2);
    chk(q[96], 1'b1);
    rst_b = 1'b0;
    u_itb_ctrl_model.drive(96, 2'h1, 16'h2, 1'b0);
    u_itb_ctrl_model.drive(33, 2'h2, 16'h3, 1'b0);
    chk(q[96], 1'b0);
    chk(q[33], 1'b0);
    chk(et[33], 16'h0);
    rst_b = 1'b1;
    cyc(5 * T1);
    chk(q[96], 1'b0);
    chk(et[96], 16'h0);
    chk(q[33], 1'b0);
    $display("Test mid-run reset done");
    u_itb_ctrl_model.drive(5, 2'h0, 16'h0, 1'b1);
    cyc(3);
    chk(q[5], 1'b0);
    $display("Test index done");
    report_and_stop();
  end
endmodule // test_itb_timer_bank
`default_nettype wire
